//--- logic/headphone_left_route_defs.vh
// Offsets, field positions, reset values and timing counts for the left headphone register bank.
`ifndef HEADPHONE_LEFT_ROUTE_DEFS_VH
`define HEADPHONE_LEFT_ROUTE_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RIGHT_DAC_TO_LEFT_HP_GAIN_OFS 8'h32
`define LEFT_HP_LEVEL_CONTROL_OFS 8'h33
`define LINE2_LEFT_TO_LEFT_COMMON_GAIN_OFS 8'h34
`define LEFT_PGA_TO_LEFT_COMMON_GAIN_OFS 8'h35
`define LEFT_DAC_TO_LEFT_COMMON_GAIN_OFS 8'h36
`define LINE2_RIGHT_TO_LEFT_COMMON_GAIN_OFS 8'h37
`define RIGHT_PGA_TO_LEFT_COMMON_GAIN_OFS 8'h38

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ROUTE_BIT 7
`define GAIN_MSB 6
`define GAIN_LSB 0
`define LEVEL_MSB 7
`define LEVEL_LSB 4
`define UNMUTE_BIT 3
`define HIZ_DOWN_BIT 2
`define PENDING_BIT 1
`define POWER_UP_BIT 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ROUTE_GAIN_RESET 8'h00
`define LEVEL_RESET 4'h0
`define UNMUTE_RESET 1'b0
`define HIZ_DOWN_RESET 1'b1
`define PENDING_RESET 1'b1
`define POWER_UP_RESET 1'b0
`define UNMAPPED_READ 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLOCK_MHZ 40
`define GAIN_STEP_NS 1000
`define GAIN_STEP_CYCLES ((`GAIN_STEP_NS * `CLOCK_MHZ) / 1000)

`endif

//--- logic/route_gain_reg.v
// One routing-enable and 7-bit gain register with host write access.
`timescale 1ns/10ps

module route_gain_reg (
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Host write strobe and data.
  input wire wr_hit,
  input wire [7:0] wdata,
  // Stored fields.
  output reg route_q,
  output reg [6:0] gain_q
);

`include "headphone_left_route_defs.vh"

  // Both fields reset to zero, so nothing is routed after power-on.
  always @(posedge clock) begin
    if (!rst_b) begin
      // Both fields take their share of the all-zero reset byte.
      route_q <= 1'b0;
      gain_q <= 7'h00;
    end else if (wr_hit) begin
      route_q <= wdata[`ROUTE_BIT];
      gain_q <= wdata[`GAIN_MSB:`GAIN_LSB];
    end
  end

endmodule

//--- logic/gain_ramp.v
// Steps an applied gain code toward its programmed target and flags pending work.
`timescale 1ns/10ps

module gain_ramp #(
  parameter WIDTH = 7,
  parameter STEP_CYCLES = 40
) (
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Programmed target code.
  input wire [WIDTH-1:0] target,
  // Applied code and pending flag.
  output reg [WIDTH-1:0] applied_q,
  output reg busy_q
);

  reg [15:0] tick_q;
  reg [WIDTH-1:0] applied_d;
  wire tick;

  assign tick = (tick_q == 16'h0000);

  // One code per step avoids audible zipper noise from large jumps.
  always @* begin
    applied_d = applied_q;
    if (tick && (applied_q < target)) begin
      applied_d = applied_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (tick && (applied_q > target)) begin
      applied_d = applied_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Busy starts high at reset and drops once applied matches target.
  always @(posedge clock) begin
    if (!rst_b) begin
      tick_q <= 16'h0000;
      applied_q <= {WIDTH{1'b0}};
      busy_q <= 1'b1;
    end else begin
      tick_q <= tick ? STEP_CYCLES[15:0] - 16'h0001 : tick_q - 16'h0001;
      applied_q <= applied_d;
      busy_q <= (applied_d != target);
    end
  end

endmodule

//--- logic/headphone_left_route_regs.v
// Register bank for the left headphone driver and its companion driver.
`timescale 1ns/10ps

// The step count default below needs the timing macros before the header is parsed.
`include "headphone_left_route_defs.vh"

module headphone_left_route_regs #(
  parameter STEP_CYCLES = `GAIN_STEP_CYCLES
) (
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Register port.
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q,
  // Right converter path into the left headphone driver.
  output wire right_converter_path_route,
  output wire [6:0] right_converter_path_gain,
  output wire [6:0] right_converter_path_applied,
  // Left headphone driver controls and status.
  output reg [3:0] left_headphone_driver_level_q,
  output wire [3:0] left_headphone_driver_level_applied,
  output reg left_headphone_driver_unmute_q,
  output reg left_headphone_driver_hiz_down_q,
  output reg left_headphone_driver_power_up_q,
  output reg left_headphone_driver_pending_q,
  // Companion driver sources.
  output wire second_left_line_route,
  output wire [6:0] second_left_line_gain,
  output wire left_gain_stage_route,
  output wire [6:0] left_gain_stage_gain,
  output wire left_converter_path_route,
  output wire [6:0] left_converter_path_gain,
  output wire second_right_line_route,
  output wire [6:0] second_right_line_gain,
  output wire right_gain_stage_route,
  output wire [6:0] right_gain_stage_gain
);

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function [7:0] pack;
    input r;
    input [6:0] g;
    begin
      pack = {r, g};
    end
  endfunction

  wire wr_dac_r;
  wire wr_level;
  wire wr_line2_l;
  wire wr_pga_l;
  wire wr_dac_l;
  wire wr_line2_r;
  wire wr_pga_r;
  wire ramp_busy_gain;
  wire ramp_busy_level;

  // Write strobes, one per mapped register.
  assign wr_dac_r = wr_en && hit(addr, `RIGHT_DAC_TO_LEFT_HP_GAIN_OFS);
  assign wr_level = wr_en && hit(addr, `LEFT_HP_LEVEL_CONTROL_OFS);
  assign wr_line2_l = wr_en && hit(addr, `LINE2_LEFT_TO_LEFT_COMMON_GAIN_OFS);
  assign wr_pga_l = wr_en && hit(addr, `LEFT_PGA_TO_LEFT_COMMON_GAIN_OFS);
  assign wr_dac_l = wr_en && hit(addr, `LEFT_DAC_TO_LEFT_COMMON_GAIN_OFS);
  assign wr_line2_r = wr_en && hit(addr, `LINE2_RIGHT_TO_LEFT_COMMON_GAIN_OFS);
  assign wr_pga_r = wr_en && hit(addr, `RIGHT_PGA_TO_LEFT_COMMON_GAIN_OFS);

  // ----------------------------------------------------------------------------
  // Routing and gain registers
  // ----------------------------------------------------------------------------

  route_gain_reg u_dac_r (
    .clock(clock),
    .rst_b(rst_b),
    .wr_hit(wr_dac_r),
    .wdata(wdata),
    .route_q(right_converter_path_route),
    .gain_q(right_converter_path_gain)
  );

  route_gain_reg u_line2_l (
    .clock(clock),
    .rst_b(rst_b),
    .wr_hit(wr_line2_l),
    .wdata(wdata),
    .route_q(second_left_line_route),
    .gain_q(second_left_line_gain)
  );

  route_gain_reg u_pga_l (
    .clock(clock),
    .rst_b(rst_b),
    .wr_hit(wr_pga_l),
    .wdata(wdata),
    .route_q(left_gain_stage_route),
    .gain_q(left_gain_stage_gain)
  );

  route_gain_reg u_dac_l (
    .clock(clock),
    .rst_b(rst_b),
    .wr_hit(wr_dac_l),
    .wdata(wdata),
    .route_q(left_converter_path_route),
    .gain_q(left_converter_path_gain)
  );

  route_gain_reg u_line2_r (
    .clock(clock),
    .rst_b(rst_b),
    .wr_hit(wr_line2_r),
    .wdata(wdata),
    .route_q(second_right_line_route),
    .gain_q(second_right_line_gain)
  );

  route_gain_reg u_pga_r (
    .clock(clock),
    .rst_b(rst_b),
    .wr_hit(wr_pga_r),
    .wdata(wdata),
    .route_q(right_gain_stage_route),
    .gain_q(right_gain_stage_gain)
  );

  // ----------------------------------------------------------------------------
  // Level control register
  // ----------------------------------------------------------------------------

  // Level, mute, drive mode and power bits; the status bit is not writable.
  // The reserved level codes are stored as written; keeping them out is the host's job.
  always @(posedge clock) begin
    if (!rst_b) begin
      left_headphone_driver_level_q <= `LEVEL_RESET;
      left_headphone_driver_unmute_q <= `UNMUTE_RESET;
      left_headphone_driver_hiz_down_q <= `HIZ_DOWN_RESET;
      left_headphone_driver_power_up_q <= `POWER_UP_RESET;
    end else if (wr_level) begin
      left_headphone_driver_level_q <= wdata[`LEVEL_MSB:`LEVEL_LSB];
      left_headphone_driver_unmute_q <= wdata[`UNMUTE_BIT];
      left_headphone_driver_hiz_down_q <= wdata[`HIZ_DOWN_BIT];
      left_headphone_driver_power_up_q <= wdata[`POWER_UP_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // Gain application tracking
  // ----------------------------------------------------------------------------

  // Both the path gain and the output level ramp to their targets.
  gain_ramp #(
    .WIDTH(7),
    .STEP_CYCLES(STEP_CYCLES)
  ) u_ramp_gain (
    .clock(clock),
    .rst_b(rst_b),
    .target(right_converter_path_gain),
    .applied_q(right_converter_path_applied),
    .busy_q(ramp_busy_gain)
  );

  gain_ramp #(
    .WIDTH(4),
    .STEP_CYCLES(STEP_CYCLES)
  ) u_ramp_level (
    .clock(clock),
    .rst_b(rst_b),
    .target(left_headphone_driver_level_q),
    .applied_q(left_headphone_driver_level_applied),
    .busy_q(ramp_busy_level)
  );

  always @(posedge clock) begin
    if (!rst_b) begin
      left_headphone_driver_pending_q <= `PENDING_RESET;
    end else begin
      // The ramps see a new target one edge late, so a fresh mismatch is added directly.
      // This raises the status on the first edge after a write rather than on the second.
      left_headphone_driver_pending_q <= ramp_busy_gain | ramp_busy_level |
        (right_converter_path_applied != right_converter_path_gain) |
        (left_headphone_driver_level_applied != left_headphone_driver_level_q);
    end
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------

  // Read data is registered; it holds its value between reads.
  always @(posedge clock) begin
    if (!rst_b) begin
      rdata_q <= `UNMAPPED_READ;
    end else if (rd_en) begin
      case (addr)
        `RIGHT_DAC_TO_LEFT_HP_GAIN_OFS: begin
          rdata_q <= pack(right_converter_path_route, right_converter_path_gain);
        end
        `LEFT_HP_LEVEL_CONTROL_OFS: begin
          rdata_q <= {left_headphone_driver_level_q, left_headphone_driver_unmute_q,
                      left_headphone_driver_hiz_down_q, left_headphone_driver_pending_q,
                      left_headphone_driver_power_up_q};
        end
        `LINE2_LEFT_TO_LEFT_COMMON_GAIN_OFS: begin
          rdata_q <= pack(second_left_line_route, second_left_line_gain);
        end
        `LEFT_PGA_TO_LEFT_COMMON_GAIN_OFS: begin
          rdata_q <= pack(left_gain_stage_route, left_gain_stage_gain);
        end
        `LEFT_DAC_TO_LEFT_COMMON_GAIN_OFS: begin
          rdata_q <= pack(left_converter_path_route, left_converter_path_gain);
        end
        `LINE2_RIGHT_TO_LEFT_COMMON_GAIN_OFS: begin
          rdata_q <= pack(second_right_line_route, second_right_line_gain);
        end
        `RIGHT_PGA_TO_LEFT_COMMON_GAIN_OFS: begin
          rdata_q <= pack(right_gain_stage_route, right_gain_stage_gain);
        end
        default: begin
          rdata_q <= `UNMAPPED_READ;
        end
      endcase
    end
  end

endmodule

//--- dv/hp_left_props.sv
// Assertions on the ports of the left headphone register bank.
`timescale 1ns/10ps
module hp_left_props (
  // Clock, reset and register port.
  input wire clock,
  input wire rst_b,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata_q,
  // Driver fields and status.
  input wire right_converter_path_route,
  input wire [6:0] right_converter_path_gain,
  input wire [6:0] right_converter_path_applied,
  input wire [3:0] left_headphone_driver_level_q,
  input wire [3:0] left_headphone_driver_level_applied,
  input wire left_headphone_driver_unmute_q,
  input wire left_headphone_driver_hiz_down_q,
  input wire left_headphone_driver_power_up_q,
  input wire left_headphone_driver_pending_q,
  input wire second_left_line_route,
  input wire [6:0] second_left_line_gain
);
  reg [7:0] wd_q;
  // Readback image of the level byte, and whether every ramp has reached its target.
  wire [7:0] lvl_byte = {left_headphone_driver_level_q, left_headphone_driver_unmute_q,
    left_headphone_driver_hiz_down_q, left_headphone_driver_pending_q,
    left_headphone_driver_power_up_q};
  wire settled = right_converter_path_applied == right_converter_path_gain &&
    left_headphone_driver_level_applied == left_headphone_driver_level_q;
  // Last cycle's write data, kept so write checks compare against a plain register.
  always @(posedge clock) begin
    wd_q <= wdata;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_route;
    wr_en && addr == 8'h32 |=> {right_converter_path_route, right_converter_path_gain} == wd_q;
  endproperty
  a_route: assert property (p_route) else $error("route write lost");
  property p_level;
    wr_en && addr == 8'h33 |=> {lvl_byte[7:2], lvl_byte[0]} == {wd_q[7:2], wd_q[0]};
  endproperty
  a_level: assert property (p_level) else $error("level write lost");
  property p_line;
    wr_en && addr == 8'h34 |=> {second_left_line_route, second_left_line_gain} == wd_q;
  endproperty
  a_line: assert property (p_line) else $error("line write lost");
  property p_busy;
    !settled |=> left_headphone_driver_pending_q;
  endproperty
  a_busy: assert property (p_busy) else $error("pending low during ramp");
  property p_idle;
    settled [*3] |-> !left_headphone_driver_pending_q;
  endproperty
  a_idle: assert property (p_idle) else $error("pending stuck high");
  property p_read;
    rd_en && addr == 8'h33 |=> rdata_q == $past(lvl_byte);
  endproperty
  a_read: assert property (p_read) else $error("level readback wrong");
  property p_hole;
    rd_en && (addr < 8'h32 || addr > 8'h38) |=> rdata_q == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_hold;
    !rd_en |=> $stable(rdata_q);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule

bind headphone_left_route_regs hp_left_props hp_left_props_i (.*);

//--- dv/host_ctl.sv
// Host controller model that drives the register port of the bank.
`timescale 1ns/10ps
module host_ctl (
  // Clock.
  input wire clock,
  // Register port toward the bank.
  output reg wr_en = 1'b0,
  output reg rd_en = 1'b0,
  output reg [7:0] addr = 8'h00,
  output reg [7:0] wdata = 8'h00,
  input wire [7:0] rdata_q
);
  // One write, held for one taken edge; idle lines then flip so stale data never looks valid.
  task wr(input [7:0] a, input [7:0] d);
    begin
      if (a == 8'h33 && d[7:4] > 4'h9) d[7:4] = 4'h9;
      @(posedge clock);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr_en <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
    end
  endtask
  // One read; the data is taken once the edge that accepted it has settled.
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clock);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      addr <= ~a;
      #1 d = rdata_q;
    end
  endtask
endmodule

//--- dv/headphone_left_route_regs_tb.sv
// Self-checking bench for the left headphone register bank.
`timescale 1ns/10ps
module headphone_left_route_regs_tb;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  wire wr_en, rd_en, hiz, pwr, pend;
  wire [7:0] addr, wdata, rdata_q;
  wire [6:0] gain_app;
  wire [3:0] lvl_app;
  integer bad_count = 0;
  integer checked = 0;
  integer cycles = 0;
  integer i;
  reg [7:0] v;
  // Rows of address, write data and expected readback.
  reg [23:0] rows [0:6] = '{24'h32ffff, 24'h322a2a, 24'h34a5a5, 24'h355a5a, 24'h36ffff,
    24'h378181, 24'h387e7e};
  // A short ramp step keeps the level sweep quick.
  headphone_left_route_regs #(.STEP_CYCLES(4)) headphone_left_route_regs_i (
    .clock(clock), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata_q(rdata_q), .right_converter_path_route(),
    .right_converter_path_gain(), .right_converter_path_applied(gain_app),
    .left_headphone_driver_level_q(), .left_headphone_driver_level_applied(lvl_app),
    .left_headphone_driver_unmute_q(), .left_headphone_driver_hiz_down_q(hiz),
    .left_headphone_driver_power_up_q(pwr), .left_headphone_driver_pending_q(pend),
    .second_left_line_route(), .second_left_line_gain(), .left_gain_stage_route(),
    .left_gain_stage_gain(), .left_converter_path_route(), .left_converter_path_gain(),
    .second_right_line_route(), .second_right_line_gain(), .right_gain_stage_route(),
    .right_gain_stage_gain());
  host_ctl host_ctl_i (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata_q(rdata_q));
  // The 40 MHz clock.
  always #12.5 clock = ~clock;
  // Cycle ceiling, so a ramp that never settles still ends the run.
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  // Counts one comparison and reports a mismatch at once.
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Writes a gain or level change, sees pending rise, then waits a bounded time for it to clear.
  task step(input [7:0] a, input [7:0] d);
    integer n;
    begin
      host_ctl_i.wr(a, d);
      @(posedge clock);
      #1;
      check("pend", 8'h01, {7'h00, pend});
      n = 0;
      while (pend !== 1'b0 && n < 100) begin
        @(posedge clock);
        #1;
        n = n + 1;
      end
      check("settle", 8'h00, {7'h00, pend});
    end
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    check("pend rst", 8'h01, {7'h00, pend});
    check("hiz rst", 8'h01, {7'h00, hiz});
    check("pwr rst", 8'h00, {7'h00, pwr});
    for (i = 0; i < 7; i = i + 1) begin
      host_ctl_i.rd(8'h32 + i[7:0], v);
      check("reset", (i == 1) ? 8'h04 : 8'h00, v);
    end
    for (i = 0; i < 7; i = i + 1) begin
      host_ctl_i.wr(rows[i][23:16], rows[i][15:8]);
      host_ctl_i.rd(rows[i][23:16], v);
      check("row", rows[i][7:0], v);
    end
    step(8'h32, 8'h05);
    check("gain app", 8'h05, {1'b0, gain_app});
    // Level codes 1 through 9, with the status bit written high and ignored.
    for (i = 1; i < 10; i = i + 1) begin
      step(8'h33, {i[3:0], 4'hf});
      host_ctl_i.rd(8'h33, v);
      check("level", {i[3:0], 4'hd}, v);
      check("lvl app", {4'h0, i[3:0]}, {4'h0, lvl_app});
    end
    step(8'h33, 8'h02);
    host_ctl_i.rd(8'h33, v);
    check("muted", 8'h00, v);
    check("hiz", 8'h00, {7'h00, hiz});
    // Writes outside the map go nowhere and read as zero.
    host_ctl_i.wr(8'h31, 8'hff);
    host_ctl_i.wr(8'h39, 8'h00);
    host_ctl_i.rd(8'h39, v);
    check("unmapped", 8'h00, v);
    host_ctl_i.rd(8'h36, v);
    check("kept", 8'hff, v);
    // A second reset in mid-run clears the bank again.
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    host_ctl_i.rd(8'h34, v);
    check("rst 34", 8'h00, v);
    host_ctl_i.rd(8'h33, v);
    check("rst 33", 8'h04, v);
    test_done;
  end
endmodule
